// ==== include/sfa_pkg.sv ====
// constants for the spi frame access host (master) controller
// assumes a 20 MHz system clock and an spi slave using mode 0 or 3
// Function
// - slave works only in spi modes 0, 3
// - frame: address, direction, count, data bytes
// - byte three: direction and upper count bits
// - burst carries only data after header
// - read sends dummy byte per data byte
// - write sends one data byte per count
// - select low before first address bit
// - select high whenever no frame runs
// - select high only after last byte
// - mosi low after select before header
package sfa_pkg;
   localparam int SFA_ADDR_W = 16;
   localparam int SFA_LEN_W = 15;
   localparam int SFA_BYTE_W = 8;
   localparam int SFA_HDR_BYTES = 4;
   localparam logic [7:0] SFA_CMD_READ = 8'h00;
   localparam logic [7:0] SFA_CMD_WRITE = 8'h80;
   localparam logic [14:0] SFA_LEN_HI_MASK = 15'h7F00;
   localparam int SFA_LEN_HI_SHIFT = 8;
   localparam int SFA_DIR_BIT = 7;
   // clock divider: half period of the generated serial clock in ref_clk cycles
   localparam int SFA_HALF_PERIOD = 2;
   localparam int SFA_DIV_W = 4;
   localparam int SFA_BIT_W = 3;
   localparam int SFA_IDX_W = 2;
   localparam logic [2:0] SFA_LAST_BIT = 3'h7;
   typedef enum {SFA_IDLE, SFA_SETUP, SFA_LOW, SFA_HIGH, SFA_HOLD, SFA_DONE} sfa_state_type;
endpackage

// ==== rtl/sfa_host.sv ====
// spi master that runs one framed read or write access per request
// assumes the slave pin miso arrives asynchronously and is resynchronised
`timescale 1ns/1ps
module sfa_host (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // request side
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [sfa_pkg::SFA_ADDR_W-1:0] req_addr,
   input wire logic [sfa_pkg::SFA_LEN_W-1:0] req_len,
   output logic req_ready,
   // write data, one byte per wr_take pulse
   input wire logic [sfa_pkg::SFA_BYTE_W-1:0] wr_data,
   output logic wr_take,
   // read data
   output logic [sfa_pkg::SFA_BYTE_W-1:0] rd_data,
   output logic rd_valid,
   output logic [sfa_pkg::SFA_ADDR_W-1:0] rd_addr,
   output logic done,
   // spi pins
   output logic cs_n,
   output logic sclk,
   output logic mosi,
   input wire logic miso
);
   import sfa_pkg::*;

   sfa_state_type st_q, st_d;
   logic [SFA_DIV_W-1:0] div_q, div_d;
   logic [SFA_BIT_W-1:0] bit_q, bit_d;
   logic [SFA_IDX_W-1:0] hidx_q, hidx_d;
   logic hdr_q, hdr_d;
   logic dir_q, dir_d;
   logic [SFA_LEN_W-1:0] cnt_q, cnt_d, len_q, len_d;
   logic [SFA_ADDR_W-1:0] addr_q, addr_d, cur_q, cur_d;
   logic [7:0] sh_q, sh_d, rx_q, rx_d;
   logic cs_n_q, cs_n_d, sclk_q, sclk_d, mosi_q, mosi_d;
   logic ready_q, ready_d, take_q, take_d, rv_q, rv_d, done_q, done_d;
   logic [7:0] rdat_q, rdat_d;
   logic [SFA_ADDR_W-1:0] raddr_q, raddr_d;
   logic miso_s1_q, miso_s2_q;

   // header byte n of the frame
   function automatic logic [7:0] hdr_byte(input logic [1:0] n, input logic [15:0] a,
                                           input logic d, input logic [14:0] l);
      case (n)
         2'h0: hdr_byte = a[15:8];
         2'h1: hdr_byte = a[7:0];
         2'h2: hdr_byte = (d ? SFA_CMD_WRITE : SFA_CMD_READ) |
                          8'((l & SFA_LEN_HI_MASK) >> SFA_LEN_HI_SHIFT);
         default: hdr_byte = l[7:0];
      endcase
   endfunction

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         miso_s1_q <= 1'b0;
         miso_s2_q <= 1'b0;
      end else begin
         miso_s1_q <= miso;
         miso_s2_q <= miso_s1_q;
      end
   end

   always_comb begin
      st_d = st_q;
      div_d = div_q;
      bit_d = bit_q;
      hidx_d = hidx_q;
      hdr_d = hdr_q;
      dir_d = dir_q;
      cnt_d = cnt_q;
      len_d = len_q;
      addr_d = addr_q;
      cur_d = cur_q;
      sh_d = sh_q;
      rx_d = rx_q;
      cs_n_d = cs_n_q;
      sclk_d = sclk_q;
      mosi_d = mosi_q;
      ready_d = ready_q;
      take_d = 1'b0;
      rv_d = 1'b0;
      done_d = 1'b0;
      rdat_d = rdat_q;
      raddr_d = raddr_q;
      case (st_q)
         SFA_IDLE: begin
            cs_n_d = 1'b1;
            sclk_d = 1'b0;
            mosi_d = 1'b0;
            ready_d = 1'b1;
            // zero-length requests are dropped: the frame needs at least one byte
            if (req_valid && ready_q && req_len != '0) begin
               ready_d = 1'b0;
               dir_d = req_write;
               addr_d = req_addr;
               cur_d = req_addr;
               len_d = req_len;
               cnt_d = req_len;
               hidx_d = '0;
               hdr_d = 1'b1;
               bit_d = '0;
               sh_d = hdr_byte(2'h0, req_addr, req_write, req_len);
               cs_n_d = 1'b0;
               mosi_d = 1'b0;
               div_d = '0;
               st_d = SFA_SETUP;
            end
         end
         SFA_SETUP: begin
            div_d = div_q + 1'b1;
            if (div_q == SFA_DIV_W'(SFA_HALF_PERIOD - 1)) begin
               div_d = '0;
               mosi_d = sh_q[7];
               st_d = SFA_LOW;
            end
         end
         SFA_LOW: begin
            div_d = div_q + 1'b1;
            if (div_q == SFA_DIV_W'(SFA_HALF_PERIOD - 1)) begin
               div_d = '0;
               sclk_d = 1'b1;
               st_d = SFA_HIGH;
            end
         end
         SFA_HIGH: begin
            div_d = div_q + 1'b1;
            if (div_q == SFA_DIV_W'(SFA_HALF_PERIOD - 1)) begin
               div_d = '0;
               sclk_d = 1'b0;
               sh_d = {sh_q[6:0], 1'b0};
               // the synchroniser lags two cycles, so the level seen at the rise
               // only reaches miso_s2_q here, before the slave moves it again
               rx_d = {rx_q[6:0], miso_s2_q};
               bit_d = bit_q + 1'b1;
               st_d = SFA_LOW;
               mosi_d = sh_q[6];
               if (bit_q == SFA_LAST_BIT) begin
                  if (hdr_q) begin
                     if (hidx_q == SFA_IDX_W'(SFA_HDR_BYTES - 1)) begin
                        hdr_d = 1'b0;
                        // write: fetch first data byte; read: dummy byte
                        sh_d = dir_q ? wr_data : 8'h00;
                        take_d = dir_q;
                     end else begin
                        hidx_d = hidx_q + 1'b1;
                        sh_d = hdr_byte(hidx_q + 1'b1, addr_q, dir_q, len_q);
                     end
                  end else begin
                     if (!dir_q) begin
                        rv_d = 1'b1;
                        rdat_d = {rx_q[6:0], miso_s2_q};
                        raddr_d = cur_q;
                     end
                     cur_d = cur_q + 1'b1;
                     cnt_d = cnt_q - 1'b1;
                     if (cnt_q == SFA_LEN_W'(1)) begin
                        st_d = SFA_HOLD;
                     end else begin
                        sh_d = dir_q ? wr_data : 8'h00;
                        take_d = dir_q;
                     end
                  end
                  mosi_d = sh_d[7];
               end
            end
         end
         SFA_HOLD: begin
            mosi_d = 1'b0;
            div_d = div_q + 1'b1;
            if (div_q == SFA_DIV_W'(SFA_HALF_PERIOD - 1)) begin
               div_d = '0;
               cs_n_d = 1'b1;
               done_d = 1'b1;
               st_d = SFA_DONE;
            end
         end
         SFA_DONE: begin
            // keeps select high for a full half period between frames
            div_d = div_q + 1'b1;
            if (div_q == SFA_DIV_W'(SFA_HALF_PERIOD - 1)) begin
               div_d = '0;
               ready_d = 1'b1;
               st_d = SFA_IDLE;
            end
         end
         default: st_d = SFA_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= SFA_IDLE;
         div_q <= '0;
         bit_q <= '0;
         hidx_q <= '0;
         hdr_q <= 1'b0;
         dir_q <= 1'b0;
         cnt_q <= '0;
         len_q <= '0;
         addr_q <= '0;
         cur_q <= '0;
         sh_q <= 8'h00;
         rx_q <= 8'h00;
         cs_n_q <= 1'b1;
         sclk_q <= 1'b0;
         mosi_q <= 1'b0;
         ready_q <= 1'b0;
         take_q <= 1'b0;
         rv_q <= 1'b0;
         done_q <= 1'b0;
         rdat_q <= 8'h00;
         raddr_q <= '0;
      end else begin
         st_q <= st_d;
         div_q <= div_d;
         bit_q <= bit_d;
         hidx_q <= hidx_d;
         hdr_q <= hdr_d;
         dir_q <= dir_d;
         cnt_q <= cnt_d;
         len_q <= len_d;
         addr_q <= addr_d;
         cur_q <= cur_d;
         sh_q <= sh_d;
         rx_q <= rx_d;
         cs_n_q <= cs_n_d;
         sclk_q <= sclk_d;
         mosi_q <= mosi_d;
         ready_q <= ready_d;
         take_q <= take_d;
         rv_q <= rv_d;
         done_q <= done_d;
         rdat_q <= rdat_d;
         raddr_q <= raddr_d;
      end
   end

   assign req_ready = ready_q;
   assign wr_take = take_q;
   assign rd_data = rdat_q;
   assign rd_valid = rv_q;
   assign rd_addr = raddr_q;
   assign done = done_q;
   assign cs_n = cs_n_q;
   assign sclk = sclk_q;
   assign mosi = mosi_q;
endmodule

// ==== verification/sfa_chk.sv ====
// pin assertions for the spi frame access host
// assumes bind into sfa_host, mode 0, sclk half period of two cycles
`timescale 1ns/1ps
module sfa_chk (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // request
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic [sfa_pkg::SFA_LEN_W-1:0] req_len,
   input wire logic done,
   // spi
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic mosi
);
   import sfa_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   AST_TAKE_SEL: assert property (req_valid && req_ready && req_len != 0 |=> !cs_n && !req_ready)
      else $error("select late");
   AST_ZERO_LEN: assert property (req_valid && req_ready && req_len == 0 |=> cs_n && req_ready)
      else $error("empty frame");
   AST_IDLE_CLK: assert property (cs_n |-> !sclk)
      else $error("clock outside frame");
   AST_MOSI_LOW: assert property ($fell(cs_n) |-> !mosi)
      else $error("mosi not low");
   AST_RISE_HOLD: assert property ($rose(sclk) |-> $stable(mosi) && !cs_n)
      else $error("mosi moved at rise");
   AST_HIGH_TIME: assert property ($rose(sclk) |=> sclk ##1 !sclk)
      else $error("clock high time");
   AST_DONE_RISE: assert property (done |-> $rose(cs_n))
      else $error("done without release");
   AST_READY_BACK: assert property (done |-> ##[1:4] req_ready)
      else $error("ready late");
endmodule
bind sfa_host sfa_chk u_sfa_chk (.ref_clk, .rst_n, .req_valid, .req_ready, .req_len, .done,
   .cs_n, .sclk, .mosi);

// ==== verification/sfa_dev_model.sv ====
// behavioural slave: 64k byte memory behind the framed spi access
// assumes the master keeps select low for the whole frame
`timescale 1ns/1ps
module sfa_dev_model (
   // spi pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic mosi,
   output logic miso
);
   logic [7:0] mem [0:65535];
   logic [31:0] hdr_q;
   logic [7:0] tx_q;
   logic [15:0] ptr_q;
   logic wr_q;
   int n;
   // only edges inside a frame count, so either idle level works
   always @(negedge cs_n) begin
      n = 0;
      miso = 1'b0;
   end
   // miso flips on release, so its level between frames means nothing
   always @(posedge cs_n) miso = ~miso;
   always @(posedge sclk) if (!cs_n) begin
      hdr_q = {hdr_q[30:0], mosi};
      n++;
      if (n == 16) ptr_q = hdr_q[15:0];
      if (n == 32) wr_q = hdr_q[15];
      if (n > 32 && n % 8 == 0 && wr_q) begin
         mem[ptr_q] = hdr_q[7:0];
         ptr_q++;
      end
   end
   always @(negedge sclk) if (!cs_n && n >= 32 && !wr_q) begin
      if (n % 8 == 0) begin
         tx_q = mem[ptr_q];
         ptr_q++;
      end
      miso = tx_q[7 - n % 8];
   end
endmodule

// ==== verification/sfa_host_bench.sv ====
// self-checking bench for the spi frame access host
// assumes the slave model memory is reachable by hierarchy
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module sfa_host_bench;
   import sfa_pkg::*;
   typedef struct {logic w; logic [15:0] a; logic [14:0] l; logic [7:0] d;} sfa_row_type;
   logic ref_clk = 0, rst_n = 0, req_valid = 0, req_write = 0;
   logic [15:0] req_addr = 0, exp_a = 0, rd_addr;
   logic [14:0] req_len = 0;
   logic [7:0] wr_data = 0, rd_data;
   logic req_ready, wr_take, rd_valid, done, cs_n, sclk, mosi, miso;
   int num_errors = 0, tests_run = 0, nrd = 0;
   // direction, start, count, first write byte
   sfa_row_type rows [4] = '{'{0, 16'h1234, 15'h1, 8'h0}, '{0, 16'h00FE, 15'h3, 8'h0},
      '{1, 16'h2000, 15'h1, 8'h3C}, '{1, 16'h01FF, 15'h4, 8'h81}};
   always #25 ref_clk = ~ref_clk;
   sfa_host u_sfa_host (.ref_clk, .rst_n, .req_valid, .req_write, .req_addr, .req_len,
      .req_ready, .wr_data, .wr_take, .rd_data, .rd_valid, .rd_addr, .done, .cs_n, .sclk,
      .mosi, .miso);
   sfa_dev_model u_sfa_dev_model (.cs_n, .sclk, .mosi, .miso);
   always @(negedge ref_clk) begin
      if (wr_take === 1'b1) wr_data <= wr_data + 8'h11;
      if (rd_valid === 1'b1) begin
         `CHK(rd_addr, exp_a)
         `CHK(rd_data, exp_a[7:0] ^ 8'hA5)
         exp_a = exp_a + 16'h1;
         nrd++;
      end
   end
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic run(input sfa_row_type r);
      int k;
      k = 0;
      while (req_ready !== 1'b1 && k < 50) begin
         @(negedge ref_clk);
         k++;
      end
      `CHK(req_ready, 1'b1)
      exp_a = r.a;
      nrd = 0;
      wr_data = r.d;
      req_write = r.w;
      req_addr = r.a;
      req_len = r.l;
      req_valid = 1'b1;
      @(negedge ref_clk);
      req_valid = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 2000) begin
         @(negedge ref_clk);
         k++;
      end
      `CHK(k < 2000, 1'b1)
      for (int i = 0; i < r.l; i++)
         if (r.w) `CHK(u_sfa_dev_model.mem[r.a + i], 8'(r.d + 8'h11 * i))
      if (!r.w) `CHK(nrd, int'(r.l))
      $display("test at %h done", r.a);
   endtask
   initial begin
      for (int i = 0; i < 65536; i++) u_sfa_dev_model.mem[i] = 8'(i) ^ 8'hA5;
      repeat (10) @(negedge ref_clk);
      rst_n = 1'b1;
      foreach (rows[i]) run(rows[i]);
      // an empty request must not open a frame
      req_len = 15'h0;
      req_valid = 1'b1;
      repeat (4) @(negedge ref_clk);
      `CHK({cs_n, req_ready}, 2'b11)
      $display("test empty done");
      req_len = 15'h8;
      @(negedge ref_clk);
      req_valid = 1'b0;
      repeat (60) @(negedge ref_clk);
      rst_n = 1'b0;
      @(negedge ref_clk);
      `CHK({cs_n, sclk}, 2'b10)
      rst_n = 1'b1;
      $display("test abort done");
      run(rows[1]);
      tally_and_finish();
   end
   initial begin
      #1000000;
      num_errors++;
      tally_and_finish();
   end
endmodule
